// *** hw/vfs_top.sv ***
// top: protection, supervision and internal gate sequencing of the vr controller
// Operation
// R1 - drive a phase's FET on only after feedback shows the other one is off
// R2 - in discontinuous mode, turn low side off on switch-node zero crossing
// R3 - cpu phases 1-2 use internal drivers; phase 3 and gpu use pwm outputs
// R4 - block conversion until both bias supplies pass start threshold, with hysteresis
// R5 - battery input has no lockout; only bias monitors gate start-up
// R6 - per-channel power ok high only inside setpoint +220/-315 mV window
// R7 - both power ok outputs drop at once on enable low or bias fault
// R8 - ignore power ok window violations during setpoint transitions
// R9 - below lower limit: drivers off, power ok low, latched until enable cycled
// R10 - overcurrent limit acts per phase and per pulse
// R11 - while current exceeds limit, postpone that phase's next on-pulse
// R12 - output above setpoint +220 mV: power ok low, low side on, latched
// R13 - never blanked 1.7 V overvoltage forces power ok low, low sides on, latched
// R14 - eight-bit thermal zone status, bit 7 drives the hot output
// R15 - thermistor at lowest threshold turns drivers off and shuts output down
// R16 - internal 155 C trip shuts down until 20 C cooler, then enable cycle
// R17 - latched faults clear only after enable seen low; restart on next enable
module vfs_top #(
  parameter int NPH = 4 // phases: 0,1 cpu internal, 2 cpu external, 3 gpu
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        regulator_enable,
  input  wire logic [11:0] driver_bias_supply,   // 10 mV units
  input  wire logic [11:0] logic_bias_supply,    // 10 mV units
  input  wire logic [11:0] cpu_vout,             // mV
  input  wire logic [11:0] gpu_vout,             // mV
  input  wire logic [11:0] cpu_setpoint,         // mV
  input  wire logic [11:0] gpu_setpoint,         // mV
  input  wire logic        cpu_slewing,
  input  wire logic        gpu_slewing,
  input  wire logic        cpu_ov_blank,
  input  wire logic        gpu_ov_blank,
  input  wire logic [11:0] cpu_thermistor_sense, // mV
  input  wire logic [11:0] gpu_thermistor_sense, // mV
  input  wire logic [7:0]  die_temp,             // degrees C
  input  wire logic [3:0]  pwm_request,          // per-phase on-pulse request
  input  wire logic [3:0]  overcurrent_limit,    // comparator: sense above limit
  input  wire logic [1:0]  low_side_gate_drive,  // feedback, internal phases
  input  wire logic [1:0]  switch_node_sense,    // high while switch node high
  input  wire logic [1:0]  zero_cross,           // switch-node current reversal
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [1:0]  high_side_gate,
  output logic      [1:0]  low_side_gate,
  output logic      [1:0]  ext_pwm,              // phase 2 and gpu phase
  output logic      [1:0]  ext_pwm_en,           // low: external driver tri-states
  output logic             cpu_power_ok_oe,
  output logic             gpu_power_ok_oe,
  output logic             regulator_hot_n_oe,
  output logic             irq
);
  logic       bias_ok;
  logic       en_d;
  logic       cpu_pok;
  logic       gpu_pok;
  logic [1:0] uv_lat;
  logic [1:0] ov_lat;
  logic       tshdn_lat;
  logic       otp_lat;
  logic       otp_hot;
  logic [7:0] zone;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic [7:0] ctrl;
  logic [7:0] prev_ev;
  logic [3:0] ocp_hold;
  vfs_pkg::vfs_phase_e ph_st [2];
  logic       run;
  logic       any_ov;
  logic       discontinuous_conduction;
  logic [7:0] next_zone;
  logic [7:0] ev;

  // true when v lies within [sp - lo, sp + hi]; widened to avoid wrap
  function automatic logic in_window(input logic [11:0] v, input logic [11:0] sp);
    logic [12:0] vv;
    vv = {1'b0, v};
    in_window = (vv + {1'b0, vfs_pkg::PG_LOWER_MV} >= {1'b0, sp}) &&
                (vv <= {1'b0, sp} + {1'b0, vfs_pkg::PG_UPPER_MV});
  endfunction

  function automatic logic above_ov(input logic [11:0] v, input logic [11:0] sp);
    above_ov = {1'b0, v} > {1'b0, sp} + {1'b0, vfs_pkg::PG_UPPER_MV};
  endfunction

  function automatic logic below_uv(input logic [11:0] v, input logic [11:0] sp);
    below_uv = {1'b0, v} + {1'b0, vfs_pkg::PG_LOWER_MV} < {1'b0, sp};
  endfunction

  assign discontinuous_conduction = ctrl[0];

  // bias lockout with falling hysteresis; battery input deliberately unmonitored [R4] [R5]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bias_ok <= 1'b0;
    end else if (bias_ok) begin
      bias_ok <= (driver_bias_supply > vfs_pkg::BIAS_START_MV - vfs_pkg::BIAS_HYST_MV) &&
                 (logic_bias_supply > vfs_pkg::BIAS_START_MV - vfs_pkg::BIAS_HYST_MV); // [R4]
    end else begin
      bias_ok <= (driver_bias_supply >= vfs_pkg::BIAS_START_MV) &&
                 (logic_bias_supply >= vfs_pkg::BIAS_START_MV); // [R4]
    end
  end

  // enable history for restart detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_d <= 1'b0;
    end else begin
      en_d <= regulator_enable;
    end
  end

  // output fault latches; cleared only while enable is low [R17]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      uv_lat    <= 2'b00;
      ov_lat    <= 2'b00;
      tshdn_lat <= 1'b0;
    end else if (!regulator_enable) begin
      uv_lat    <= 2'b00; // [R17]
      ov_lat    <= 2'b00; // [R17]
      tshdn_lat <= 1'b0;  // [R17]
    end else begin
      // uv only armed while running and not slewing, else start-up would trip it
      if (run && !cpu_slewing && below_uv(cpu_vout, cpu_setpoint)) begin
        uv_lat[0] <= 1'b1; // [R9]
      end
      if (run && !gpu_slewing && below_uv(gpu_vout, gpu_setpoint)) begin
        uv_lat[1] <= 1'b1; // [R9]
      end
      if ((!cpu_ov_blank && above_ov(cpu_vout, cpu_setpoint)) || cpu_vout > vfs_pkg::ABS_OV_MV) begin
        ov_lat[0] <= 1'b1; // [R12] [R13]
      end
      if ((!gpu_ov_blank && above_ov(gpu_vout, gpu_setpoint)) || gpu_vout > vfs_pkg::ABS_OV_MV) begin
        ov_lat[1] <= 1'b1; // [R12] [R13]
      end
      if (cpu_thermistor_sense <= vfs_pkg::THERM_SHDN_MV ||
          gpu_thermistor_sense <= vfs_pkg::THERM_SHDN_MV) begin
        tshdn_lat <= 1'b1; // [R15]
      end
    end
  end

  // die over-temperature: holds until cooled, then waits for enable cycle [R16]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      otp_hot <= 1'b0;
      otp_lat <= 1'b0;
    end else begin
      if (die_temp >= vfs_pkg::TEMP_TRIP_C) begin
        otp_hot <= 1'b1; // [R16]
      end else if (die_temp <= vfs_pkg::TEMP_TRIP_C - vfs_pkg::TEMP_HYST_C) begin
        otp_hot <= 1'b0; // [R16]
      end
      if (die_temp >= vfs_pkg::TEMP_TRIP_C) begin
        otp_lat <= 1'b1;
      end else if (!otp_hot && !regulator_enable) begin
        otp_lat <= 1'b0; // [R16] [R17]
      end
    end
  end

  assign any_ov = |ov_lat;
  // conversion runs only with enable, bias and no shutdown latch [R4] [R15] [R16]
  assign run = regulator_enable && en_d && bias_ok && !tshdn_lat && !otp_lat;

  // thermal zone: bit i sets as the lower of both thermistors falls below its level [R14]
  always_comb begin
    logic [11:0] t;
    t = (cpu_thermistor_sense < gpu_thermistor_sense) ? cpu_thermistor_sense : gpu_thermistor_sense;
    for (int i = 0; i < 8; i++) begin
      next_zone[i] = t < vfs_pkg::ZONE_MV[7 - i]; // [R14]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      zone <= vfs_pkg::ZONE_RESET;
    end else begin
      zone <= next_zone; // [R14]
    end
  end

  // power ok window, masked during slew, dropped at once on enable or bias loss [R6] [R7] [R8]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_pok <= 1'b0;
      gpu_pok <= 1'b0;
    end else if (!regulator_enable || !bias_ok || !run) begin
      cpu_pok <= 1'b0; // [R7]
      gpu_pok <= 1'b0; // [R7]
    end else begin
      if (uv_lat[0] || ov_lat[0]) begin
        cpu_pok <= 1'b0; // [R9] [R12]
      end else if (!cpu_slewing) begin
        cpu_pok <= in_window(cpu_vout, cpu_setpoint); // [R6] [R8]
      end
      if (uv_lat[1] || ov_lat[1]) begin
        gpu_pok <= 1'b0; // [R9] [R12]
      end else if (!gpu_slewing) begin
        gpu_pok <= in_window(gpu_vout, gpu_setpoint); // [R6] [R8]
      end
    end
  end

  // open-drain outputs: enable high pulls low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_power_ok_oe    <= 1'b1;
      gpu_power_ok_oe    <= 1'b1;
      regulator_hot_n_oe <= 1'b0;
    end else begin
      cpu_power_ok_oe    <= !cpu_pok;
      gpu_power_ok_oe    <= !gpu_pok;
      regulator_hot_n_oe <= zone[7]; // [R14]
    end
  end

  // overcurrent hold: a request arriving above limit waits until limit clears [R10] [R11]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ocp_hold <= 4'h0;
    end else begin
      for (int p = 0; p < NPH; p++) begin
        ocp_hold[p] <= overcurrent_limit[p]; // [R10] [R11]
      end
    end
  end

  // internal phase sequencing with break-before-make from pin feedback [R1] [R2] [R3]
  for (genvar g = 0; g < 2; g++) begin : g_int
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        ph_st[g]          <= vfs_pkg::VFS_PH_OFF;
        high_side_gate[g] <= 1'b0;
        low_side_gate[g]  <= 1'b0;
      end else if (any_ov && regulator_enable) begin
        // overvoltage crowbar overrides everything except enable low, even shutdown of the converter
        high_side_gate[g] <= 1'b0;
        low_side_gate[g]  <= !switch_node_sense[g]; // [R12] [R13] [R1]
        ph_st[g]          <= vfs_pkg::VFS_PH_LOW;
      end else if (!run || uv_lat[0]) begin
        high_side_gate[g] <= 1'b0; // [R9] [R15] [R16]
        low_side_gate[g]  <= 1'b0;
        ph_st[g]          <= vfs_pkg::VFS_PH_OFF;
      end else begin
        case (ph_st[g])
          vfs_pkg::VFS_PH_OFF, vfs_pkg::VFS_PH_LOW: begin
            if (pwm_request[g] && !ocp_hold[g] && !overcurrent_limit[g]) begin
              low_side_gate[g] <= 1'b0;
              ph_st[g]         <= vfs_pkg::VFS_PH_DEAD; // [R10] [R11]
            end else if (discontinuous_conduction && zero_cross[g]) begin
              low_side_gate[g] <= 1'b0; // [R2]
              ph_st[g]         <= vfs_pkg::VFS_PH_OFF;
            end else if (ph_st[g] == vfs_pkg::VFS_PH_LOW && !switch_node_sense[g]) begin
              low_side_gate[g] <= 1'b1; // [R1]
            end
          end
          vfs_pkg::VFS_PH_DEAD: begin
            if (!low_side_gate_drive[g]) begin
              high_side_gate[g] <= 1'b1; // [R1]
              ph_st[g]          <= vfs_pkg::VFS_PH_HIGH;
            end
          end
          vfs_pkg::VFS_PH_HIGH: begin
            if (!pwm_request[g]) begin
              high_side_gate[g] <= 1'b0;
              ph_st[g]          <= vfs_pkg::VFS_PH_LOW; // low side waits for node to fall [R1]
            end
          end
          default: begin
            high_side_gate[g] <= 1'b0;
            low_side_gate[g]  <= 1'b0;
            ph_st[g]          <= vfs_pkg::VFS_PH_OFF;
          end
        endcase
      end
    end
  end

  // external driver pwm for cpu phase 3 and gpu phase [R3]
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_pwm    <= 2'b00;
      ext_pwm_en <= 2'b00;
    end else begin
      ext_pwm_en[0] <= run && !uv_lat[0] || any_ov && regulator_enable; // [R3] [R9]
      ext_pwm_en[1] <= run && !uv_lat[1] || any_ov && regulator_enable; // [R3] [R9]
      // pwm low with driver enabled means low side on: used as crowbar
      ext_pwm[0] <= run && !uv_lat[0] && !ov_lat[0] && pwm_request[2] && !overcurrent_limit[2]; // [R3] [R11]
      ext_pwm[1] <= run && !uv_lat[1] && !ov_lat[1] && pwm_request[3] && !overcurrent_limit[3]; // [R3] [R11]
    end
  end

  // events for interrupt status
  assign ev = {otp_lat, !bias_ok, tshdn_lat, zone[7], ov_lat[1], ov_lat[0], uv_lat[1], uv_lat[0]};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_ev <= 8'(1 << vfs_pkg::EV_BIAS); // bias reads lost out of reset: no false event
    end else begin
      prev_ev <= ev;
    end
  end

  // sticky status: rising event wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= 8'h00;
    end else begin
      irq_stat <= (irq_stat & ~((reg_wr && reg_addr == vfs_pkg::ADDR_IRQ_STAT) ? reg_wdata : 8'h00))
                  | (ev & ~prev_ev);
    end
  end

  // writable registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= vfs_pkg::MASK_RESET;
      ctrl     <= vfs_pkg::CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == vfs_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata;
      end
      if (reg_addr == vfs_pkg::ADDR_CTRL) begin
        ctrl <= {7'h00, reg_wdata[0]};
      end
    end
  end

  // read port, one cycle latency; unmapped reads zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
      if (reg_rd) begin
        case (reg_addr)
          vfs_pkg::ADDR_ZONE:     reg_rdata <= zone;
          vfs_pkg::ADDR_STATUS:   reg_rdata <= {run, bias_ok, otp_hot, tshdn_lat, ov_lat, uv_lat};
          vfs_pkg::ADDR_IRQ_STAT: reg_rdata <= irq_stat;
          vfs_pkg::ADDR_IRQ_MASK: reg_rdata <= irq_mask;
          vfs_pkg::ADDR_CTRL:     reg_rdata <= ctrl;
          default:                reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // vfs_top

// *** hw/vfs_pkg.sv ***
// package: thresholds, encodings and reset values for the vr fault supervisor
package vfs_pkg;
  // analog voltages arrive as millivolt codes, bias supplies as 10 mV codes, from converters outside this block
  localparam int MV_W = 12;
  localparam logic [11:0] BIAS_START_MV   = 12'h1B8; // 4400 mV in units of 10 mV
  localparam logic [11:0] BIAS_HYST_MV    = 12'h014; // 200 mV in units of 10 mV
  localparam logic [11:0] PG_UPPER_MV     = 12'h0DC; // 220 mV
  localparam logic [11:0] PG_LOWER_MV     = 12'h13B; // 315 mV
  localparam logic [11:0] ABS_OV_MV       = 12'h6A4; // 1700 mV
  localparam logic [11:0] THERM_SHDN_MV   = 12'h19A; // 410 mV
  localparam logic [11:0] ZONE_MV [8]     = '{12'h1C7, 12'h1CA, 12'h20B, 12'h22F,
                                              12'h256, 12'h27E, 12'h2A8, 12'h30F};
  // index 0 above is b7 (455 mV) ... index 7 is b0 (783 mV)
  localparam logic [7:0]  TEMP_TRIP_C     = 8'h9B;  // 155 C
  localparam logic [7:0]  TEMP_HYST_C     = 8'h14;  // 20 C
  localparam logic [7:0]  ZONE_RESET      = 8'h00;
  // register map
  localparam logic [3:0]  ADDR_ZONE       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h3;
  localparam logic [3:0]  ADDR_CTRL       = 4'h4;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  // event bits
  localparam int EV_CPU_UV = 0;
  localparam int EV_GPU_UV = 1;
  localparam int EV_CPU_OV = 2;
  localparam int EV_GPU_OV = 3;
  localparam int EV_HOT    = 4;
  localparam int EV_TSHDN  = 5;
  localparam int EV_BIAS   = 6;
  localparam int EV_OTP    = 7;
  // phase driver states
  typedef enum logic [3:0] {
    VFS_PH_OFF  = 4'b0001,
    VFS_PH_HIGH = 4'b0010,
    VFS_PH_DEAD = 4'b0100,
    VFS_PH_LOW  = 4'b1000
  } vfs_phase_e;
endpackage : vfs_pkg

// *** tb/vfs_top_chk.sv ***
// checker: port-level assertions for the vr fault supervisor
module vfs_top_chk (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        regulator_enable,
  input wire logic [11:0] driver_bias_supply,
  input wire logic [11:0] logic_bias_supply,
  input wire logic [11:0] cpu_vout,
  input wire logic [11:0] gpu_vout,
  input wire logic [11:0] cpu_setpoint,
  input wire logic        cpu_slewing,
  input wire logic        cpu_ov_blank,
  input wire logic [11:0] cpu_thermistor_sense,
  input wire logic [11:0] gpu_thermistor_sense,
  input wire logic [7:0]  die_temp,
  input wire logic [3:0]  overcurrent_limit,
  input wire logic [1:0]  low_side_gate_drive,
  input wire logic [1:0]  switch_node_sense,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  high_side_gate,
  input wire logic [1:0]  low_side_gate,
  input wire logic [1:0]  ext_pwm,
  input wire logic        cpu_power_ok_oe,
  input wire logic        gpu_power_ok_oe,
  input wire logic        regulator_hot_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] BIAS_LOW = vfs_pkg::BIAS_START_MV - vfs_pkg::BIAS_HYST_MV;
  localparam logic [11:0] HOT_MV   = vfs_pkg::ZONE_MV[0];
  logic [12:0] cpu_hi;
  logic [12:0] cpu_lo;
  logic        low_therm;
  // thirteen bits so setpoint plus margin cannot wrap
  assign cpu_hi    = {1'b0, cpu_setpoint} + {1'b0, vfs_pkg::PG_UPPER_MV};
  assign cpu_lo    = {1'b0, cpu_vout} + {1'b0, vfs_pkg::PG_LOWER_MV};
  assign low_therm = (cpu_thermistor_sense < HOT_MV) || (gpu_thermistor_sense < HOT_MV);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_high_after_low: assert property ((high_side_gate & ~$past(high_side_gate) & $past(low_side_gate_drive)) == 2'b00)
    else $error("high gate rose while low fet still on");
  a_low_after_node: assert property ((low_side_gate & ~$past(low_side_gate) & $past(switch_node_sense)) == 2'b00)
    else $error("low gate rose while switch node high");
  a_ocp_holds_pulse: assert property ((ext_pwm & ~$past(ext_pwm) & $past(overcurrent_limit[3:2])) == 2'b00)
    else $error("external pulse started during overcurrent");
  a_enable_drops_pok: assert property (!regulator_enable [*3] |-> cpu_power_ok_oe && gpu_power_ok_oe)
    else $error("power ok active with enable low");
  a_bias_lockout: assert property ((driver_bias_supply < BIAS_LOW || logic_bias_supply < BIAS_LOW) [*4] |->
    cpu_power_ok_oe && gpu_power_ok_oe && high_side_gate == 2'b00) else $error("running on low bias");
  a_cpu_ov_window: assert property (regulator_enable && !cpu_slewing && !cpu_ov_blank && {1'b0, cpu_vout} > cpu_hi
    |-> ##[1:3] cpu_power_ok_oe) else $error("cpu overvoltage kept power ok");
  a_cpu_uv_window: assert property (regulator_enable && !cpu_slewing && cpu_lo < {1'b0, cpu_setpoint}
    |-> ##[1:4] cpu_power_ok_oe && high_side_gate == 2'b00) else $error("cpu undervoltage kept running");
  a_abs_ov_trip: assert property (regulator_enable && gpu_vout > vfs_pkg::ABS_OV_MV |-> ##[1:3] gpu_power_ok_oe)
    else $error("fixed overvoltage kept gpu power ok");
  a_hot_follows_zone: assert property (low_therm [*3] |-> regulator_hot_n_oe)
    else $error("hot output not asserted");
  a_hot_clear_zone: assert property (!low_therm [*3] |-> !regulator_hot_n_oe)
    else $error("hot output asserted while cool");
  a_therm_shutdown: assert property (cpu_thermistor_sense <= vfs_pkg::THERM_SHDN_MV
    |-> ##[1:3] high_side_gate == 2'b00 && low_side_gate == 2'b00) else $error("drivers on at thermal shutdown");
  a_die_trip_off: assert property (die_temp >= vfs_pkg::TEMP_TRIP_C |-> ##[1:3] high_side_gate == 2'b00 &&
    cpu_power_ok_oe) else $error("running above die trip");
  a_rdata_idle: assert property ((!$past(reg_rd) || $past(reg_addr) > 4'h4) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle or unmapped");
  c_ext_pulse: cover property ($rose(ext_pwm[1]));
  c_pok_drop: cover property ($rose(cpu_power_ok_oe) && regulator_enable);
  c_hot_seen: cover property ($rose(regulator_hot_n_oe));
endmodule // vfs_top_chk

bind vfs_top vfs_top_chk vfs_top_chk_inst (.*);

// *** tb/vfs_stage.sv ***
// power stage model: gate feedback and switch node with a selectable lag
module vfs_stage (
  input  wire logic       ref_clk,
  input  wire logic [1:0] high_side_gate,
  input  wire logic [1:0] low_side_gate,
  input  wire logic       slow,
  output logic      [1:0] low_side_gate_drive,
  output logic      [1:0] switch_node_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] hs_d = 6'h00;
  logic [5:0] ls_d = 6'h00;
  // turn-off history; a slow fet lingers three cycles, a fast one one
  always @(posedge ref_clk) begin
    hs_d <= {hs_d[3:0], high_side_gate};
    ls_d <= {ls_d[3:0], low_side_gate};
  end
  // turn-on shows at once, turn-off late, so early switching overlaps
  assign low_side_gate_drive = low_side_gate | ls_d[1:0] | ({2{slow}} & (ls_d[3:2] | ls_d[5:4]));
  assign switch_node_sense   = high_side_gate | hs_d[1:0] | ({2{slow}} & (hs_d[3:2] | hs_d[5:4]));
endmodule // vfs_stage

// *** tb/vfs_top_test.sv ***
// testbench: register, phase and fault scenarios for the vr fault supervisor
module vfs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, regulator_enable = 0, cpu_slewing = 0, gpu_slewing = 0;
  logic cpu_ov_blank = 0, gpu_ov_blank = 0, reg_wr = 0, reg_rd = 0, slow = 0, rd_q = 0, irq_a;
  logic [11:0] driver_bias_supply = 12'h1F4, logic_bias_supply = 12'h1F4, cpu_vout = 12'h3E8;
  logic [11:0] gpu_vout = 12'h3E8, cpu_setpoint = 12'h3E8, gpu_setpoint = 12'h3E8;
  logic [11:0] cpu_thermistor_sense = 12'h320, gpu_thermistor_sense = 12'h320;
  logic [7:0]  die_temp = 8'h32, reg_wdata = 8'h00, reg_rdata, exp_v;
  logic [3:0]  pwm_request = 4'h0, overcurrent_limit = 4'h0, reg_addr = 4'h0;
  logic [1:0]  zero_cross = 2'h0, low_side_gate_drive, switch_node_sense;
  logic [1:0]  high_side_gate, low_side_gate, ext_pwm, ext_pwm_en;
  logic        cpu_power_ok_oe, gpu_power_ok_oe, regulator_hot_n_oe, irq;
  logic [7:0]  exp_q [$];
  logic [7:0]  ev [6] = '{8'h01, 8'h04, 8'h08, 8'h30, 8'h80, 8'h40}; // event per fault case
  int          mismatches = 0, check_count = 0, i, k, s;

  vfs_top vfs_top_inst (.*);
  vfs_stage vfs_stage_inst (.*);

  always #50 ref_clk = ~ref_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // bounded wait; a hang counts as a mismatch and closes the run
  task automatic wait_hs(input logic [1:0] m);
    int n;
    for (n = 0; n < 20 && (high_side_gate & m) !== m; n++) tick(1);
    if (n == 20) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic cycle_en();
    regulator_enable <= 1'b0;
    tick(4);
    regulator_enable <= 1'b1;
    tick(6);
  endtask

  // read data stands one cycle after the strobe; take the oldest note then
  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q) check(reg_rdata, exp_q.pop_front());
  end

  initial begin
    s = $urandom(32'h470e);
    tick(2);
    resetn <= 1'b1;
    rd(vfs_pkg::ADDR_ZONE, vfs_pkg::ZONE_RESET);
    rd(vfs_pkg::ADDR_IRQ_MASK, vfs_pkg::MASK_RESET);
    rd(vfs_pkg::ADDR_CTRL, vfs_pkg::CTRL_RESET);
    rd(vfs_pkg::ADDR_IRQ_STAT, 8'h00);
    rd(4'hF, 8'h00);
    check(8'(cpu_power_ok_oe & gpu_power_ok_oe), 8'h01);
    regulator_enable <= 1'b1;
    driver_bias_supply <= 12'h1A5; // above the falling threshold only
    tick(8);
    check(8'({cpu_power_ok_oe, gpu_power_ok_oe}), 8'h00);
    wr(vfs_pkg::ADDR_IRQ_STAT, 8'hFF);
    rd(vfs_pkg::ADDR_IRQ_STAT, 8'h00);
    rd(vfs_pkg::ADDR_STATUS, 8'hC0);
    driver_bias_supply <= 12'h1F4;
    // slow stage, phase 1 held off by overcurrent while phase 0 runs
    slow <= 1'b1;
    overcurrent_limit <= 4'h2;
    pwm_request <= 4'h3;
    wait_hs(2'b01);
    check(8'({high_side_gate[1], low_side_gate[0]}), 8'h00);
    overcurrent_limit <= 4'h8;
    wait_hs(2'b10);
    pwm_request <= 4'hC;
    tick(6);
    check(8'(ext_pwm), 8'h01);
    check(8'(ext_pwm_en), 8'h03);
    overcurrent_limit <= 4'h0;
    tick(4);
    check(8'({ext_pwm, high_side_gate}), 8'h0C);
    pwm_request <= 4'h0;
    tick(8);
    check(8'(low_side_gate), 8'h03);
    wr(vfs_pkg::ADDR_CTRL, 8'h01);
    zero_cross <= 2'b01;
    tick(4);
    check(8'(low_side_gate), 8'h02);
    zero_cross <= 2'b00;
    wr(vfs_pkg::ADDR_CTRL, 8'h00);
    // sag during a setpoint move must not drop power ok
    cpu_slewing <= 1'b1;
    gpu_slewing <= 1'b1;
    cpu_vout <= 12'h3E8 - 12'(316 + $urandom_range(80));
    gpu_vout <= 12'h3E8 - 12'(316 + $urandom_range(80));
    tick(5);
    check(8'({cpu_power_ok_oe, gpu_power_ok_oe}), 8'h00);
    cpu_vout <= 12'h3E8;
    gpu_vout <= 12'h3E8;
    tick(2);
    cpu_slewing <= 1'b0;
    gpu_slewing <= 1'b0;
    // zone boundaries, each just on or just under its threshold
    for (i = 0; i < 8; i++) begin
      cpu_thermistor_sense <= vfs_pkg::ZONE_MV[i] - 12'($urandom_range(1));
      tick(4);
      exp_v = 8'h00;
      for (k = 0; k < 8; k++) exp_v[k] = cpu_thermistor_sense < vfs_pkg::ZONE_MV[7-k];
      rd(vfs_pkg::ADDR_ZONE, exp_v);
      check(8'(regulator_hot_n_oe), 8'(exp_v[7]));
    end
    cpu_thermistor_sense <= 12'h1A0;
    tick(4);
    cpu_thermistor_sense <= 12'h320;
    tick(4);
    rd(vfs_pkg::ADDR_IRQ_STAT, 8'h10);
    wr(vfs_pkg::ADDR_IRQ_MASK, 8'h00);
    tick(2);
    irq_a = irq;
    wr(vfs_pkg::ADDR_IRQ_MASK, 8'hFF);
    tick(2);
    check(8'(irq ^ irq_a), 8'h01);
    wr(vfs_pkg::ADDR_IRQ_STAT, 8'h10);
    rd(vfs_pkg::ADDR_IRQ_STAT, 8'h00);
    check(8'(irq), 8'h00);
    // faults: uv, cpu ov, fixed ov on gpu, thermistor, die, bias
    for (k = 0; k < 6; k++) begin
      pwm_request <= 4'hF;
      gpu_ov_blank <= k == 2;
      case (k)
        0: cpu_vout <= 12'h3E8 - 12'h13C;
        1: cpu_vout <= 12'h3E8 + 12'h0DD;
        2: gpu_vout <= 12'h6A5;
        3: cpu_thermistor_sense <= 12'h19A;
        4: die_temp <= vfs_pkg::TEMP_TRIP_C;
        default: logic_bias_supply <= 12'h1A3;
      endcase
      tick(8);
      check(8'(k == 2 ? gpu_power_ok_oe : cpu_power_ok_oe), 8'h01);
      if (k != 2) check(8'(high_side_gate), 8'h00);
      if (k == 1) check(8'(low_side_gate), 8'h03);
      if (k == 0) check(8'(ext_pwm_en), 8'h02);
      rd(vfs_pkg::ADDR_IRQ_STAT, ev[k]);
      cpu_vout <= 12'h3E8;
      gpu_vout <= 12'h3E8;
      cpu_thermistor_sense <= 12'h320;
      die_temp <= 8'h87;
      logic_bias_supply <= 12'h1F4;
      tick(6);
      if (k != 3 && k != 5) check(8'(k == 2 ? gpu_power_ok_oe : cpu_power_ok_oe), 8'h01);
      wr(vfs_pkg::ADDR_IRQ_STAT, ev[k]);
      pwm_request <= 4'h0;
      cycle_en();
      check(8'({cpu_power_ok_oe, gpu_power_ok_oe}), 8'h00);
    end
    // reset in mid-run brings the mask back to its reset value
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    rd(vfs_pkg::ADDR_IRQ_MASK, vfs_pkg::MASK_RESET);
    rd(vfs_pkg::ADDR_IRQ_STAT, 8'h00);
    tick(4);
    wrap_up();
  end
endmodule // vfs_top_test
